// ==== include/hfd_regs.vh ====
`ifndef HFD_REGS_VH
`define HFD_REGS_VH
// ----------------------------------------
// Frame byte fields
// ----------------------------------------
`define HFD_TAG_BIT      7
`define HFD_GAIN_HI      6
`define HFD_GAIN_LO      5
`define HFD_TICK_HI      4
`define HFD_TICK_LO      3
`define HFD_IDXL_HI      2
`define HFD_IDXL_LO      0
`define HFD_REP_HI       6
`define HFD_REP_LO       3
`define HFD_RCMD_BIT     2
`define HFD_RATE8_BIT    1
`define HFD_IDXH_BIT     0
// ----------------------------------------
// Snippet point fields
// ----------------------------------------
`define HFD_RAMP_BIT     7
`define HFD_DUR_HI       6
`define HFD_DUR_LO       4
`define HFD_LVL_HI       3
`define HFD_LVL_LO       0
// ----------------------------------------
// Built-in silent snippet
// ----------------------------------------
`define HFD_SILENT_TICKS 4'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define HFD_CLK_PERIOD_NS 20
`define HFD_TICK_BASE_NS  1360000
`define HFD_TICK_BASE_CYC (`HFD_TICK_BASE_NS / `HFD_CLK_PERIOD_NS)
`define HFD_MULT_X1       7'h01
`define HFD_MULT_X4       7'h04
`define HFD_MULT_X16      7'h10
`define HFD_MULT_X32      7'h20
`define HFD_MULT_X64      7'h40
// ----------------------------------------
// Drive rate
// ----------------------------------------
`define HFD_RATE_STEP_HZ  2
`define HFD_RATE_MIN_HZ   10'h019
`define HFD_PERIOD_NUM_US 20'hF4240
`define HFD_DIV_STEPS     5'h14
// ----------------------------------------
// Reset values
// ----------------------------------------
`define HFD_RST_RATE      9'h000
`define HFD_RST_PERIOD    16'h0000
`endif

// ==== hdl/hfd_tick_timer.v ====
`timescale 1ns/1ps
`include "hfd_regs.vh"
module hfd_tick_timer #(
  parameter integer BASE_CYC = `HFD_TICK_BASE_CYC
) (
  input  wire       i_clk_sys,
  input  wire       i_srst,
  input  wire       i_restart,
  input  wire [1:0] i_code,
  input  wire       i_short,
  output reg        o_tick
);
  reg [19:0] base_q;
  reg [6:0]  mult_q;
  reg [6:0]  mult_lim;

  // ----------------------------------------
  // Tick length select.
  // ----------------------------------------
  always @* begin
    case ({i_short, i_code})
      3'b000:  mult_lim = `HFD_MULT_X4;
      3'b001:  mult_lim = `HFD_MULT_X16;
      3'b010:  mult_lim = `HFD_MULT_X32;
      3'b011:  mult_lim = `HFD_MULT_X64;
      3'b100:  mult_lim = `HFD_MULT_X1;
      3'b101:  mult_lim = `HFD_MULT_X4;
      3'b110:  mult_lim = `HFD_MULT_X16;
      default: mult_lim = `HFD_MULT_X32;
    endcase
  end

  // ----------------------------------------
  // Base counter and tick multiplier.
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    o_tick <= 1'b0;
    if (i_srst || i_restart) begin
      base_q <= 20'h00000;
      mult_q <= 7'h00;
    end else if (base_q == BASE_CYC - 1) begin
      base_q <= 20'h00000;
      if (mult_q == mult_lim - 7'h01) begin
        mult_q <= 7'h00;
        o_tick <= 1'b1;
      end else begin
        mult_q <= mult_q + 7'h01;
      end
    end else begin
      base_q <= base_q + 20'h00001;
    end
  end
endmodule // hfd_tick_timer

// ==== hdl/hfd_frame_decoder.v ====
`timescale 1ns/1ps
`include "hfd_regs.vh"
module hfd_frame_decoder #(
  parameter integer TICK_BASE_CYC = `HFD_TICK_BASE_CYC
) (
  input  wire       i_clk_sys,
  input  wire       i_srst,
  input  wire       i_seq_start,
  input  wire [7:0] i_seq_first_addr,
  input  wire [7:0] i_seq_last_addr,
  input  wire       i_short_tick_option,
  input  wire       i_resonance_tracking_enable,
  input  wire [7:0] i_mem_data,
  input  wire [7:0] i_snp_first_addr,
  input  wire [7:0] i_snp_last_addr,
  output reg  [7:0] o_mem_addr_q,
  output reg        o_mem_rd_q,
  output reg  [3:0] o_snippet_index_q,
  output reg        o_snp_req_q,
  output reg        o_busy_q,
  output reg        o_point_valid_q,
  output reg  [7:0] o_start_amp_q,
  output reg  [7:0] o_target_amp_q,
  output reg        o_ramp_flag_q,
  output reg  [3:0] o_point_ticks_q,
  output wire       o_tick,
  output reg  [8:0] o_drive_rate_code_q,
  output reg        o_rate_update_q,
  output reg [15:0] o_active_period_readback_q,
  output reg        o_mem_fault_q,
  output reg        o_seq_done_q
);
  // ----------------------------------------
  // State encoding.
  // ----------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_B1   = 8'h02;
  localparam [7:0] S_B2   = 8'h04;
  localparam [7:0] S_B3   = 8'h08;
  localparam [7:0] S_SNP  = 8'h10;
  localparam [7:0] S_PT   = 8'h20;
  localparam [7:0] S_PLAY = 8'h40;
  localparam [7:0] S_END  = 8'h80;

  // ----------------------------------------
  // Storage.
  // ----------------------------------------
  reg  [7:0]  state_q;
  reg         wait_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  seq_last_q;
  reg         seq_over_q;
  reg  [1:0]  gain_q;
  reg  [1:0]  tick_code_q;
  reg  [3:0]  repeat_q;
  reg         rate8_q;
  reg  [7:0]  pt_ptr_q;
  reg  [7:0]  snp_first_q;
  reg  [7:0]  snp_last_q;
  reg         silent_q;
  reg  [7:0]  amp_q;
  reg  [3:0]  ticks_left_q;
  reg         restart_q;
  reg  [19:0] quo_q;
  reg  [20:0] rem_q;
  reg  [10:0] div_q;
  reg  [4:0]  div_cnt_q;
  reg         div_busy_q;
  wire [20:0] trial;
  wire        fits;
  wire [9:0]  rate_hz;
  wire [10:0] rate_clamped;
  wire [7:0]  scaled;
  wire        tick_live;
  wire        div_start;

  // ----------------------------------------
  // Tick source.
  // ----------------------------------------
  hfd_tick_timer #(
    .BASE_CYC (TICK_BASE_CYC)
  ) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_restart (restart_q),
    .i_code    (tick_code_q),
    .i_short   (i_short_tick_option),
    .o_tick    (o_tick)
  );

  // ----------------------------------------
  // Amplitude scaling and rate conversion.
  // ----------------------------------------
  assign scaled = {i_mem_data[`HFD_LVL_HI:`HFD_LVL_LO], 4'h0} >> gain_q;
  assign rate_hz = {rate8_q, i_mem_data, 1'b0};
  assign rate_clamped = (rate_hz < `HFD_RATE_MIN_HZ) ?
                        {1'b0, `HFD_RATE_MIN_HZ} : {1'b0, rate_hz};
  assign trial = {rem_q[19:0], quo_q[19]};
  assign fits = (trial >= {10'h000, div_q});

  // ----------------------------------------
  // Tick and divider qualifiers.
  // ----------------------------------------
  // A tick launched before the timer restart belongs to no point.
  assign tick_live = o_tick & ~restart_q;
  assign div_start = (state_q == S_B3) && wait_q;

  // ----------------------------------------
  // Rate to period divider.
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      quo_q                      <= 20'h00000;
      rem_q                      <= 21'h000000;
      div_q                      <= 11'h000;
      div_cnt_q                  <= 5'h00;
      div_busy_q                 <= 1'b0;
      o_active_period_readback_q <= `HFD_RST_PERIOD;
    end else if (div_start) begin
      quo_q      <= `HFD_PERIOD_NUM_US;
      rem_q      <= 21'h000000;
      div_q      <= rate_clamped;
      div_cnt_q  <= 5'h00;
      div_busy_q <= 1'b1;
    end else if (div_busy_q) begin
      quo_q     <= {quo_q[18:0], fits};
      rem_q     <= fits ? (trial - {10'h000, div_q}) : trial;
      div_cnt_q <= div_cnt_q + 5'h01;
      if (div_cnt_q == `HFD_DIV_STEPS - 5'h01) begin
        div_busy_q                 <= 1'b0;
        o_active_period_readback_q <= {quo_q[14:0], fits};
      end
    end
  end

  // ----------------------------------------
  // Frame and point sequencing.
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    o_mem_rd_q      <= 1'b0;
    o_snp_req_q     <= 1'b0;
    o_point_valid_q <= 1'b0;
    o_rate_update_q <= 1'b0;
    o_mem_fault_q   <= 1'b0;
    o_seq_done_q    <= 1'b0;
    restart_q       <= 1'b0;
    wait_q          <= o_mem_rd_q | o_snp_req_q;
    if (i_srst) begin
      state_q             <= S_IDLE;
      wait_q              <= 1'b0;
      ptr_q               <= 8'h00;
      seq_last_q          <= 8'h00;
      seq_over_q          <= 1'b0;
      gain_q              <= 2'h0;
      tick_code_q         <= 2'h0;
      repeat_q            <= 4'h0;
      rate8_q             <= 1'b0;
      pt_ptr_q            <= 8'h00;
      snp_first_q         <= 8'h00;
      snp_last_q          <= 8'h00;
      silent_q            <= 1'b0;
      amp_q               <= 8'h00;
      ticks_left_q        <= 4'h0;
      o_mem_addr_q        <= 8'h00;
      o_snippet_index_q   <= 4'h0;
      o_busy_q            <= 1'b0;
      o_start_amp_q       <= 8'h00;
      o_target_amp_q      <= 8'h00;
      o_ramp_flag_q       <= 1'b0;
      o_point_ticks_q     <= 4'h0;
      o_drive_rate_code_q <= `HFD_RST_RATE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (i_seq_start) begin
            ptr_q        <= i_seq_first_addr;
            seq_last_q   <= i_seq_last_addr;
            seq_over_q   <= 1'b0;
            amp_q        <= 8'h00;
            o_busy_q     <= 1'b1;
            o_mem_addr_q <= i_seq_first_addr;
            o_mem_rd_q   <= 1'b1;
            state_q      <= S_B1;
          end
        end
        S_B1: begin
          if (wait_q) begin
            if (i_mem_data[`HFD_TAG_BIT]) begin
              o_mem_fault_q <= 1'b1;
              state_q       <= S_END;
            end else begin
              gain_q            <= i_mem_data[`HFD_GAIN_HI:`HFD_GAIN_LO];
              tick_code_q       <= i_mem_data[`HFD_TICK_HI:`HFD_TICK_LO];
              o_snippet_index_q <= {1'b0, i_mem_data[`HFD_IDXL_HI:`HFD_IDXL_LO]};
              repeat_q          <= 4'h0;
              ptr_q             <= ptr_q + 8'h01;
              if (ptr_q == seq_last_q) begin
                seq_over_q <= 1'b1;
                state_q    <= S_SNP;
              end else begin
                o_mem_addr_q <= ptr_q + 8'h01;
                o_mem_rd_q   <= 1'b1;
                state_q      <= S_B2;
              end
            end
          end
        end
        S_B2: begin
          if (wait_q) begin
            if (!i_mem_data[`HFD_TAG_BIT]) begin
              state_q <= S_SNP;
            end else begin
              repeat_q <= i_mem_data[`HFD_REP_HI:`HFD_REP_LO];
              rate8_q  <= i_mem_data[`HFD_RATE8_BIT];
              o_snippet_index_q[3] <= i_mem_data[`HFD_IDXH_BIT];
              ptr_q    <= ptr_q + 8'h01;
              if (ptr_q == seq_last_q) begin
                seq_over_q <= 1'b1;
                state_q    <= S_SNP;
              end else if (i_mem_data[`HFD_RCMD_BIT]) begin
                o_mem_addr_q <= ptr_q + 8'h01;
                o_mem_rd_q   <= 1'b1;
                state_q      <= S_B3;
              end else begin
                state_q <= S_SNP;
              end
            end
          end
        end
        S_B3: begin
          if (wait_q) begin
            o_drive_rate_code_q <= {rate8_q, i_mem_data};
            o_rate_update_q     <= 1'b1;
            ptr_q               <= ptr_q + 8'h01;
            seq_over_q          <= (ptr_q == seq_last_q);
            state_q             <= S_SNP;
          end
        end
        S_SNP: begin
          if (o_snippet_index_q == 4'h0) begin
            silent_q        <= 1'b1;
            o_start_amp_q   <= amp_q;
            o_target_amp_q  <= 8'h00;
            o_ramp_flag_q   <= 1'b0;
            o_point_ticks_q <= `HFD_SILENT_TICKS;
            ticks_left_q    <= `HFD_SILENT_TICKS;
            o_point_valid_q <= 1'b1;
            restart_q       <= 1'b1;
            state_q         <= S_PLAY;
          end else if (wait_q) begin
            silent_q     <= 1'b0;
            snp_first_q  <= i_snp_first_addr;
            snp_last_q   <= i_snp_last_addr;
            pt_ptr_q     <= i_snp_first_addr;
            o_mem_addr_q <= i_snp_first_addr;
            o_mem_rd_q   <= 1'b1;
            state_q      <= S_PT;
          end else if (!o_snp_req_q) begin
            o_snp_req_q <= 1'b1;
          end
        end
        S_PT: begin
          if (wait_q) begin
            o_start_amp_q   <= amp_q;
            o_target_amp_q  <= scaled;
            o_ramp_flag_q   <= i_mem_data[`HFD_RAMP_BIT];
            o_point_ticks_q <= {1'b0, i_mem_data[`HFD_DUR_HI:`HFD_DUR_LO]} + 4'h1;
            ticks_left_q    <= {1'b0, i_mem_data[`HFD_DUR_HI:`HFD_DUR_LO]} + 4'h1;
            o_point_valid_q <= 1'b1;
            restart_q       <= 1'b1;
            state_q         <= S_PLAY;
          end
        end
        S_PLAY: begin
          if (tick_live) begin
            if (ticks_left_q != 4'h1) begin
              ticks_left_q <= ticks_left_q - 4'h1;
            end else begin
              amp_q <= o_target_amp_q;
              if (!silent_q && pt_ptr_q != snp_last_q) begin
                pt_ptr_q     <= pt_ptr_q + 8'h01;
                o_mem_addr_q <= pt_ptr_q + 8'h01;
                o_mem_rd_q   <= 1'b1;
                state_q      <= S_PT;
              end else if (repeat_q != 4'h0) begin
                repeat_q <= repeat_q - 4'h1;
                if (silent_q) begin
                  state_q <= S_SNP;
                end else begin
                  pt_ptr_q     <= snp_first_q;
                  o_mem_addr_q <= snp_first_q;
                  o_mem_rd_q   <= 1'b1;
                  state_q      <= S_PT;
                end
              end else if (seq_over_q) begin
                state_q <= S_END;
              end else begin
                o_mem_addr_q <= ptr_q;
                o_mem_rd_q   <= 1'b1;
                state_q      <= S_B1;
              end
            end
          end
        end
        S_END: begin
          amp_q           <= 8'h00;
          o_start_amp_q   <= 8'h00;
          o_target_amp_q  <= 8'h00;
          o_ramp_flag_q   <= 1'b0;
          o_busy_q        <= 1'b0;
          o_seq_done_q    <= 1'b1;
          state_q         <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // hfd_frame_decoder

// ==== tb/hfd_frame_decoder_asserts.sv ====
`timescale 1ns/1ps
module hfd_frame_decoder_chk #(
  parameter integer TICK_BASE_CYC = 4
) (
  input wire        i_clk_sys,
  input wire        i_srst,
  input wire        i_seq_start,
  input wire [7:0]  i_seq_first_addr,
  input wire        o_mem_rd_q,
  input wire [7:0]  o_mem_addr_q,
  input wire        o_busy_q,
  input wire        o_point_valid_q,
  input wire [7:0]  o_start_amp_q,
  input wire [7:0]  o_target_amp_q,
  input wire [3:0]  o_point_ticks_q,
  input wire [8:0]  o_drive_rate_code_q,
  input wire        o_rate_update_q,
  input wire [15:0] o_active_period_readback_q,
  input wire        o_mem_fault_q,
  input wire        o_seq_done_q
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  reg         first_q;
  reg  [7:0]  last_tgt_q;
  reg  [15:0] per_exp_q;
  wire [9:0]  hz = {o_drive_rate_code_q, 1'b0};
  wire [19:0] per_full = 20'hF4240 / ((hz < 10'h019) ? 10'h019 : hz);
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      first_q <= 1'b0;
      last_tgt_q <= 8'h00;
      per_exp_q <= 16'h0000;
    end else begin
      if (i_seq_start && !o_busy_q) first_q <= 1'b1;
      else if (o_point_valid_q) first_q <= 1'b0;
      if (o_point_valid_q) last_tgt_q <= o_target_amp_q;
      if (o_rate_update_q) per_exp_q <= per_full[15:0];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_start_fetch: assert property (i_seq_start && !o_busy_q |=> o_busy_q && o_mem_rd_q &&
    o_mem_addr_q == $past(i_seq_first_addr)) else $error("start did not fetch first byte");
  a_idle_quiet: assert property (!o_busy_q |-> !o_point_valid_q && !o_mem_rd_q)
    else $error("activity while idle");
  a_seq_zero: assert property (o_point_valid_q && first_q |-> o_start_amp_q == 8'h00)
    else $error("sequence did not start at zero");
  a_amp_chain: assert property (o_point_valid_q && !first_q |-> o_start_amp_q == last_tgt_q)
    else $error("point start differs from previous end");
  a_point_len: assert property (o_point_valid_q |-> o_point_ticks_q inside {[4'h1:4'h8]})
    else $error("point length out of range");
  a_fault_end: assert property (o_mem_fault_q |=> o_seq_done_q)
    else $error("fault did not end sequence");
  a_end_zero: assert property (o_seq_done_q |=> o_target_amp_q == 8'h00 && o_start_amp_q == 8'h00)
    else $error("amplitude not zero at end");
  a_rate_hold: assert property ($changed(o_drive_rate_code_q) |-> o_rate_update_q)
    else $error("rate code changed without command");
  a_period_conv: assert property (o_rate_update_q |=> ##[0:30] o_active_period_readback_q == per_exp_q)
    else $error("period readback wrong");
endmodule // hfd_frame_decoder_chk

bind hfd_frame_decoder hfd_frame_decoder_chk #(.TICK_BASE_CYC(TICK_BASE_CYC)) u_chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_seq_start(i_seq_start),
  .i_seq_first_addr(i_seq_first_addr), .o_mem_rd_q(o_mem_rd_q), .o_mem_addr_q(o_mem_addr_q),
  .o_busy_q(o_busy_q), .o_point_valid_q(o_point_valid_q), .o_start_amp_q(o_start_amp_q),
  .o_target_amp_q(o_target_amp_q), .o_point_ticks_q(o_point_ticks_q),
  .o_drive_rate_code_q(o_drive_rate_code_q), .o_rate_update_q(o_rate_update_q),
  .o_active_period_readback_q(o_active_period_readback_q), .o_mem_fault_q(o_mem_fault_q),
  .o_seq_done_q(o_seq_done_q));

// ==== tb/hfd_mem_model.sv ====
`timescale 1ns/1ps
module hfd_mem_model (
  input  wire       i_clk_sys,
  input  wire       i_rd,
  input  wire [7:0] i_addr,
  input  wire       i_snp_req,
  input  wire [3:0] i_index,
  output reg  [7:0] o_data,
  output reg  [7:0] o_snp_first,
  output reg  [7:0] o_snp_last
);
  reg [7:0] mem [0:255];
  reg [7:0] sf  [0:15];
  reg [7:0] sl  [0:15];
  initial begin
    o_data = 8'h00;
    o_snp_first = 8'h00;
    o_snp_last = 8'h00;
  end
  // Answers one cycle after a request; otherwise the lines toggle so stale data cannot pass.
  always @(posedge i_clk_sys) begin
    if (i_rd) o_data <= mem[i_addr];
    else o_data <= ~o_data;
    if (i_snp_req) begin
      o_snp_first <= sf[i_index];
      o_snp_last <= sl[i_index];
    end else begin
      o_snp_first <= ~o_snp_first;
      o_snp_last <= ~o_snp_last;
    end
  end
endmodule // hfd_mem_model

// ==== tb/hfd_frame_decoder_tb_top.sv ====
`timescale 1ns/1ps
module hfd_frame_decoder_tb_top;
  localparam integer BASE = 4;
  localparam [287:0] IMG = {16'h109F, 16'h1108, 16'h209C, 16'h2104, 16'h4001, 16'h4841,
    16'h4989, 16'h5000, 16'h5184, 16'h520A, 16'h6000, 16'h6186, 16'h62F4, 16'h6881,
    16'h7001, 16'h7109, 16'h7211, 16'h7319};
  localparam [34:0] MUL = {7'h40, 7'h20, 7'h10, 7'h04, 7'h01};
  reg         clk;
  reg         srst;
  reg         start;
  reg  [7:0]  first;
  reg  [7:0]  last;
  reg         opt;
  wire [7:0]  mdat, sfa, sla, addr, samp, tamp;
  wire [3:0]  idx, ticks;
  wire [8:0]  rate;
  wire [15:0] per;
  wire        rd, sreq, busy, pv, ramp, tk, rupd, flt, done;
  integer     fails, cmp_count, np, nflt, nt, lt, tgap, k;
  reg  [20:0] ps [0:15];
  reg  [3:0]  pidx;
  hfd_frame_decoder #(.TICK_BASE_CYC(BASE)) uut (
    .i_clk_sys(clk), .i_srst(srst), .i_seq_start(start), .i_seq_first_addr(first),
    .i_seq_last_addr(last), .i_short_tick_option(opt),
    .i_resonance_tracking_enable(1'b0),
    .i_mem_data(mdat), .i_snp_first_addr(sfa), .i_snp_last_addr(sla), .o_mem_addr_q(addr),
    .o_mem_rd_q(rd), .o_snippet_index_q(idx), .o_snp_req_q(sreq), .o_busy_q(busy),
    .o_point_valid_q(pv), .o_start_amp_q(samp), .o_target_amp_q(tamp), .o_ramp_flag_q(ramp),
    .o_point_ticks_q(ticks), .o_tick(tk), .o_drive_rate_code_q(rate), .o_rate_update_q(rupd),
    .o_active_period_readback_q(per), .o_mem_fault_q(flt), .o_seq_done_q(done));
  hfd_mem_model mdl (.i_clk_sys(clk), .i_rd(rd), .i_addr(addr), .i_snp_req(sreq),
    .i_index(idx), .o_data(mdat), .o_snp_first(sfa), .o_snp_last(sla));
  always #10 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task play(input [7:0] a0, input [7:0] a1);
    integer n;
    begin
      np = 0;
      nflt = 0;
      nt = 0;
      tgap = 0;
      start = 1'b1;
      first = a0;
      last = a1;
      @(negedge clk);
      start = 1'b0;
      for (n = 0; n < 4000 && done !== 1'b1; n = n + 1) begin
        if (pv === 1'b1) begin
          ps[np] = {samp, tamp, ramp, ticks};
          pidx = idx;
          np = np + 1;
        end
        if (flt === 1'b1) nflt = nflt + 1;
        if (tk === 1'b1 && np > 0 && pv !== 1'b1) begin
          if (nt == 1) tgap = n - lt;
          lt = n;
          nt = nt + 1;
        end
        @(negedge clk);
      end
      if (n == 4000) begin
        fails = fails + 1;
        $display("unexpected done expected 1 seen 0");
        print_verdict;
      end else begin
        @(negedge clk);
      end
    end
  endtask
  task chk_pts(input integer cnt, input [83:0] e);
    begin
      chk("points", cnt, np);
      for (k = 0; k < cnt; k = k + 1) chk("point", e[63-21*k +: 21], ps[k]);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_basic;
    begin
      play(8'h40, 8'h40);
      chk("index", 4'h1, pidx);
      chk_pts(2, {8'h00, 8'hF0, 1'b1, 4'h2, 8'hF0, 8'h80, 1'b0, 4'h1, 42'h0});
      chk("end_amp", 8'h00, tamp);
      $display("basic frame test done");
    end
  endtask
  task t_repeat;
    begin
      play(8'h48, 8'h49);
      chk("index", 4'h9, pidx);
      chk_pts(4, {8'h00, 8'h30, 1'b1, 4'h2, 8'h30, 8'h10, 1'b0, 4'h1,
        8'h10, 8'h30, 1'b1, 4'h2, 8'h30, 8'h10, 1'b0, 4'h1});
      $display("repeat frame test done");
    end
  endtask
  task t_rate;
    begin
      play(8'h50, 8'h52);
      chk("points", 1, np);
      chk("target", 8'h00, ps[0][12:5]);
      chk("ticks", 4'h2, ps[0][3:0]);
      chk("rate", 9'h00A, rate);
      repeat (25) @(negedge clk);
      chk("period", 16'h9C40, per);
      play(8'h40, 8'h40);
      chk("rate", 9'h00A, rate);
      play(8'h60, 8'h62);
      repeat (25) @(negedge clk);
      chk("rate", 9'h1F4, rate);
      chk("period", 16'h03E8, per);
      $display("rate command test done");
    end
  endtask
  task t_fault;
    begin
      play(8'h68, 8'h68);
      chk("fault", 1, nflt);
      chk("points", 0, np);
      $display("fault test done");
    end
  endtask
  task t_ticks;
    integer o, c;
    begin
      for (o = 0; o < 2; o = o + 1) begin
        for (c = 0; c < 4; c = c + 1) begin
          opt = o[0];
          play(8'h70 + c[7:0], 8'h70 + c[7:0]);
          chk("tick_gap", BASE * MUL[7*(c+1-o) +: 7], tgap);
        end
      end
      opt = 1'b0;
      $display("tick length test done");
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    start = 1'b0;
    first = 8'h00;
    last = 8'h00;
    opt = 1'b0;
    fails = 0;
    cmp_count = 0;
    tgap = 0;
    for (k = 0; k < 18; k = k + 1) mdl.mem[IMG[16*k+8 +: 8]] = IMG[16*k +: 8];
    mdl.sf[1] = 8'h10;
    mdl.sl[1] = 8'h11;
    mdl.sf[9] = 8'h20;
    mdl.sl[9] = 8'h21;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    t_basic;
    t_repeat;
    t_rate;
    t_fault;
    t_ticks;
    print_verdict;
  end
endmodule // hfd_frame_decoder_tb_top
